// ---- bwm_write_master.sv ----
// bursting memory write master: fifo drain into sequential bursts
// Notes on behaviour
// - read data taken only in cycles with readdatavalid high.
// - variable-latency slave flags valid data; master captures then.
// - whole-word writes to consecutive addresses from the start address.
// - go captures start address and word count.
// - burst_begin strobes one cycle after capture.
// - byteenable and burstcount constant through a burst.
// - burst posted only when fifo holds the whole burst.
// - beats paused only by waitrequest once a burst starts.
// - each accepted word bumps address, drops remaining length.
// - presented address constant during a burst.
// - short final burst issued, then transfer ends.
// - master sustains beats for the whole locked burst.
`timescale 1ns/1ns
module bwm_write_master
    import bwm_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              go,
    input  wire logic [ADDR_W-1:0] start_address,
    input  wire logic [LEN_W-1:0]  transfer_length,
    output logic                   busy,
    output logic                   done,
    input  wire logic              user_valid,
    input  wire logic [DATA_W-1:0] user_data,
    output logic                   user_ready,
    output logic [ADDR_W-1:0]      master_address,
    output logic                   master_write,
    output logic [DATA_W-1:0]      master_writedata,
    output logic [BE_W-1:0]        master_byteenable,
    output logic [BURST_W-1:0]     master_burstcount,
    input  wire logic              master_waitrequest,
    input  wire logic              master_readdatavalid,
    input  wire logic [DATA_W-1:0] master_readdata,
    output logic [DATA_W-1:0]      read_word,
    output logic                   read_word_valid
);
    bwm_state_t          state_q, state_d;
    logic [ADDR_W-1:0]   addr_q, addr_d;
    logic [LEN_W-1:0]    len_q, len_d;
    logic [ADDR_W-1:0]   bus_addr_q, bus_addr_d;
    logic [BURST_W-1:0]  bcount_q, bcount_d;
    logic [BURST_W-1:0]  beats_q, beats_d;
    logic                done_q, done_d;
    logic                busy_q, busy_d;
    logic                write_q, write_d;
    logic                take_go;
    logic                burst_begin;
    logic                data_ready;
    logic                len_zero;
    logic                last_word;
    logic                beat;
    logic                last_beat;
    logic                fifo_pop;
    logic [DATA_W-1:0]   fifo_data;
    logic [USED_W-1:0]   fifo_used;
    logic [BURST_W-1:0]  next_burst;

    bwm_fifo i_bwm_fifo (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .wr_valid (user_valid),
        .wr_data  (user_data),
        .wr_ready (user_ready),
        .rd_ready (fifo_pop),
        .rd_data  (fifo_data),
        .used     (fifo_used)
    );

    bwm_rd_capture i_bwm_rd_capture (
        .clk_sys       (clk_sys),
        .reset         (reset),
        .readdatavalid (master_readdatavalid),
        .readdata      (master_readdata),
        .rd_word       (read_word),
        .rd_word_valid (read_word_valid)
    );

    // burst sizing against remaining words
    always_comb begin
        len_zero  = (len_q == '0);
        last_word = (len_q == LEN_W'(1));
        if (len_q < LEN_W'(MAX_BURST)) begin
            next_burst = BURST_W'(len_q);
        end else begin
            next_burst = MAX_BURST;
        end
        data_ready = (fifo_used >= USED_W'(next_burst));
    end

    // handshake strobes
    always_comb begin
        take_go     = (state_q == BWM_IDLE) && go;
        burst_begin = (state_q == BWM_LAUNCH) ||
                      ((state_q == BWM_WAIT_DATA) && data_ready);
        beat        = (state_q == BWM_BURST) && !master_waitrequest;
        last_beat   = beat && (beats_q == BURST_W'(1));
        fifo_pop    = beat;
    end

    // transfer sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            BWM_IDLE: begin
                if (take_go) begin
                    state_d = BWM_LAUNCH;
                end
            end
            BWM_LAUNCH: begin
                if (len_zero) begin
                    state_d = BWM_IDLE;
                end else begin
                    state_d = BWM_WAIT_DATA;
                end
            end
            BWM_WAIT_DATA: begin
                if (data_ready) begin
                    state_d = BWM_BURST;
                end
            end
            BWM_BURST: begin
                if (last_beat && last_word) begin
                    state_d = BWM_IDLE;
                end else if (last_beat) begin
                    state_d = BWM_WAIT_DATA;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= BWM_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // word address, captured at go, stepped per beat
    always_comb begin
        addr_d = addr_q;
        unique case (state_q)
            BWM_IDLE: begin
                if (take_go) begin
                    addr_d = start_address;
                end
            end
            BWM_LAUNCH, BWM_WAIT_DATA: begin
                addr_d = addr_q;
            end
            BWM_BURST: begin
                if (beat) begin
                    addr_d = addr_q + ADDR_W'(WORD_BYTES);
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            addr_q <= ADDR_RST;
        end else begin
            addr_q <= addr_d;
        end
    end

    // remaining words, captured at go, counted down per beat
    always_comb begin
        len_d = len_q;
        unique case (state_q)
            BWM_IDLE: begin
                if (take_go) begin
                    len_d = transfer_length;
                end
            end
            BWM_LAUNCH, BWM_WAIT_DATA: begin
                len_d = len_q;
            end
            BWM_BURST: begin
                if (beat) begin
                    len_d = len_q - LEN_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            len_q <= LEN_RST;
        end else begin
            len_q <= len_d;
        end
    end

    // burst base address, loaded by burst_begin only
    always_comb begin
        bus_addr_d = bus_addr_q;
        unique case (state_q)
            BWM_IDLE: begin
                bus_addr_d = bus_addr_q;
            end
            BWM_LAUNCH, BWM_WAIT_DATA: begin
                if (burst_begin) begin
                    bus_addr_d = addr_q;
                end
            end
            BWM_BURST: begin
                bus_addr_d = bus_addr_q;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bus_addr_q <= ADDR_RST;
        end else begin
            bus_addr_q <= bus_addr_d;
        end
    end

    // burst length, loaded by burst_begin only
    always_comb begin
        bcount_d = bcount_q;
        unique case (state_q)
            BWM_IDLE: begin
                bcount_d = bcount_q;
            end
            BWM_LAUNCH, BWM_WAIT_DATA: begin
                if (burst_begin) begin
                    bcount_d = next_burst;
                end
            end
            BWM_BURST: begin
                bcount_d = bcount_q;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bcount_q <= BURST_RST;
        end else begin
            bcount_q <= bcount_d;
        end
    end

    // beats left in the current burst
    always_comb begin
        beats_d = beats_q;
        unique case (state_q)
            BWM_IDLE: begin
                beats_d = beats_q;
            end
            BWM_LAUNCH, BWM_WAIT_DATA: begin
                if (burst_begin) begin
                    beats_d = next_burst;
                end
            end
            BWM_BURST: begin
                if (beat) begin
                    beats_d = beats_q - BURST_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            beats_q <= BURST_RST;
        end else begin
            beats_q <= beats_d;
        end
    end

    // completion pulse
    always_comb begin
        done_d = 1'b0;
        unique case (state_q)
            BWM_IDLE, BWM_WAIT_DATA: begin
                done_d = 1'b0;
            end
            BWM_LAUNCH: begin
                done_d = len_zero;
            end
            BWM_BURST: begin
                done_d = last_beat && last_word;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    // busy status from the next state
    always_comb begin
        busy_d = (state_d != BWM_IDLE);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    // write strobe, high for the whole burst
    always_comb begin
        write_d = (state_d == BWM_BURST);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            write_q <= 1'b0;
        end else begin
            write_q <= write_d;
        end
    end

    assign master_address    = bus_addr_q;
    assign master_write      = write_q;
    assign master_writedata  = fifo_data;
    assign master_byteenable = BE_ALL;
    assign master_burstcount = bcount_q;
    assign busy              = busy_q;
    assign done              = done_q;
endmodule : bwm_write_master

// ---- bwm_pkg.sv ----
// package of constants and types for the bursting write master
package bwm_pkg;
    localparam int ADDR_W        = 32;
    localparam int DATA_W        = 32;
    localparam int BE_W          = DATA_W / 8;
    localparam int LEN_W         = 32;
    localparam int BURST_W       = 5;
    localparam int FIFO_DEPTH    = 32;
    localparam int FIFO_AW       = 5;
    localparam int USED_W        = FIFO_AW + 1;
    localparam int WORD_BYTES    = BE_W;
    localparam logic [BURST_W-1:0] MAX_BURST = 5'h10;
    localparam logic [BE_W-1:0]    BE_ALL    = 4'hF;
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 32'h00000000;
    localparam logic [LEN_W-1:0]   LEN_RST   = 32'h00000000;
    localparam logic [BURST_W-1:0] BURST_RST = 5'h00;
    localparam logic [DATA_W-1:0]  DATA_RST  = 32'h00000000;

    typedef enum logic [1:0] {
        BWM_IDLE,
        BWM_LAUNCH,
        BWM_WAIT_DATA,
        BWM_BURST
    } bwm_state_t;
endpackage : bwm_pkg

// ---- bwm_fifo.sv ----
// word fifo feeding the write master, with a fill count
`timescale 1ns/1ns
module bwm_fifo
    import bwm_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              wr_valid,
    input  wire logic [DATA_W-1:0] wr_data,
    output logic                   wr_ready,
    input  wire logic              rd_ready,
    output logic [DATA_W-1:0]      rd_data,
    output logic [USED_W-1:0]      used
);
    logic [DATA_W-1:0]  mem_q [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [USED_W-1:0]  cnt_q, cnt_d;
    logic               push, pop;

    always_comb begin
        wr_ready = (cnt_q != USED_W'(FIFO_DEPTH));
        push     = wr_valid && wr_ready;
        pop      = rd_ready && (cnt_q != '0);
        wp_d     = push ? wp_q + FIFO_AW'(1) : wp_q;
        rp_d     = pop ? rp_q + FIFO_AW'(1) : rp_q;
        cnt_d    = cnt_q + USED_W'(push) - USED_W'(pop);
        rd_data  = mem_q[rp_q];
        used     = cnt_q;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wp_q] <= wr_data;
        end
    end
endmodule : bwm_fifo

// ---- bwm_rd_capture.sv ----
// pipelined read return capture, qualified by readdatavalid
`timescale 1ns/1ns
module bwm_rd_capture
    import bwm_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              readdatavalid,
    input  wire logic [DATA_W-1:0] readdata,
    output logic [DATA_W-1:0]      rd_word,
    output logic                   rd_word_valid
);
    logic [DATA_W-1:0] word_q, word_d;
    logic              vld_q, vld_d;

    always_comb begin
        word_d = readdatavalid ? readdata : word_q;
        vld_d  = readdatavalid;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            word_q <= DATA_RST;
            vld_q  <= 1'b0;
        end else begin
            word_q <= word_d;
            vld_q  <= vld_d;
        end
    end

    assign rd_word       = word_q;
    assign rd_word_valid = vld_q;
endmodule : bwm_rd_capture

// ---- bwm_write_master_sva.sv ----
// assertions on the bursting write master ports
`timescale 1ns/1ns
module bwm_write_master_sva
    import bwm_pkg::*;
(
    input wire logic               clk_sys,
    input wire logic               reset,
    input wire logic               go,
    input wire logic               busy,
    input wire logic               done,
    input wire logic [ADDR_W-1:0]  master_address,
    input wire logic               master_write,
    input wire logic [DATA_W-1:0]  master_writedata,
    input wire logic [BE_W-1:0]    master_byteenable,
    input wire logic [BURST_W-1:0] master_burstcount,
    input wire logic               master_waitrequest,
    input wire logic               master_readdatavalid,
    input wire logic [DATA_W-1:0]  master_readdata,
    input wire logic [DATA_W-1:0]  read_word,
    input wire logic               read_word_valid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_take;
        go && !busy;
    endsequence
    sequence s_stall;
        master_write && master_waitrequest;
    endsequence
    chk_go_busy: assert property (s_take |=> busy) else $error("busy missing after go");
    chk_be_whole: assert property (master_write |-> master_byteenable == BE_ALL)
        else $error("partial byteenable");
    chk_bc_hold: assert property (master_write && $past(master_write) |->
        $stable(master_burstcount)) else $error("burstcount moved in burst");
    chk_addr_hold: assert property (master_write && $past(master_write) |->
        $stable(master_address)) else $error("address moved in burst");
    chk_bc_range: assert property (master_write |-> master_burstcount != 5'h00
        && master_burstcount <= MAX_BURST) else $error("bad burstcount");
    chk_stall_hold: assert property (s_stall |=> master_write
        && $stable(master_writedata)) else $error("beat dropped in stall");
    chk_rd_take: assert property (master_readdatavalid |=> read_word_valid
        && read_word == $past(master_readdata)) else $error("read word lost");
    chk_rd_only: assert property (!master_readdatavalid |=> !read_word_valid)
        else $error("read taken without valid");
    chk_done_once: assert property (done |=> !done) else $error("done too long");
    chk_done_idle: assert property (done |-> !master_write) else $error("write at done");
    chk_launch_gap: assert property (s_take |=> !master_write ##1 !master_write)
        else $error("write before burst begin");
endmodule : bwm_write_master_sva
bind bwm_write_master bwm_write_master_sva i_bwm_write_master_sva (.*);

// ---- bwm_mem_slave.sv ----
// memory slave model with stalls and flagged read returns
`timescale 1ns/1ns
module bwm_mem_slave (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        stall_en,
    input wire logic        rd_en,
    input wire logic [31:0] master_address,
    input wire logic        master_write,
    input wire logic [31:0] master_writedata,
    input wire logic [4:0]  master_burstcount,
    output logic            master_waitrequest,
    output logic            master_readdatavalid,
    output logic [31:0]     master_readdata,
    output logic [15:0]     beats
);
    logic [31:0] mem [0:63];
    logic [31:0] cnt_q;
    logic [4:0]  idx_q;
    logic [1:0]  ph_q;
    assign master_waitrequest = stall_en & ph_q[0];
    assign master_readdatavalid = rd_en & (ph_q == 2'h3);
    assign master_readdata = master_readdatavalid ? cnt_q : ~cnt_q;
    // bursts of any burstcount stored from base plus beat index, beats of a locked burst in order
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ph_q <= 2'h0;
            cnt_q <= 32'h0;
            idx_q <= 5'h0;
            beats <= 16'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
            cnt_q <= cnt_q + 32'h1;
            if (master_write && !master_waitrequest) begin
                mem[6'(master_address[7:2] + 6'(idx_q))] <= master_writedata;
                beats <= beats + 16'h1;
                idx_q <= (5'(idx_q + 5'h1) == master_burstcount) ? 5'h0 : idx_q + 5'h1;
            end
        end
    end
endmodule : bwm_mem_slave

// ---- bwm_write_master_tb.sv ----
// testbench for the bursting write master
`timescale 1ns/1ns
module bwm_write_master_tb;
    logic        clk_sys, reset, go, user_valid, stall_en, rd_en, busy, done, user_ready;
    logic        master_write, master_waitrequest, master_readdatavalid, read_word_valid;
    logic [31:0] start_address, transfer_length, user_data, master_address, last;
    logic [31:0] master_writedata, master_readdata, read_word;
    logic [3:0]  master_byteenable;
    logic [4:0]  master_burstcount;
    logic [15:0] beats;
    int          num_errors = 0, checked = 0, cyc = 0, b0, nv, nw;
    bwm_write_master i_bwm_write_master (.*);
    bwm_mem_slave i_bwm_mem_slave (.*);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic feed(input int n, input logic [31:0] base);
        user_valid <= 1'b1;
        for (int k = 0; k < n; k++) begin
            user_data <= base + 32'(k);
            @(posedge clk_sys);
        end
        user_valid <= 1'b0;
    endtask : feed
    task automatic launch(input logic [31:0] a, n);
        b0 = beats;
        start_address <= a;
        transfer_length <= n;
        go <= 1'b1;
        @(posedge clk_sys);
        transfer_length <= 32'h7;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask : launch
    task automatic finish(input int n, ix, input logic [31:0] base);
        int t = 0;
        do begin
            @(negedge clk_sys);
            t++;
        end while (done !== 1'b1 && t < 3000);
        chk("done", {31'h0, done}, 32'h1);
        @(negedge clk_sys);
        chk("beats", 32'(beats - b0), n);
        for (int k = 0; k < n; k++)
            chk("word", i_bwm_mem_slave.mem[ix + k], base + 32'(k));
    endtask : finish
    task automatic t_short;
        feed(3, 32'h100);
        launch(32'h0, 32'h3);
        finish(3, 0, 32'h100);
    endtask : t_short
    task automatic t_long;
        feed(20, 32'h200);
        launch(32'h40, 32'h14);
        finish(20, 16, 32'h200);
    endtask : t_long
    task automatic t_stall;
        stall_en <= 1'b1;
        feed(16, 32'h300);
        launch(32'h0, 32'h10);
        finish(16, 0, 32'h300);
        stall_en <= 1'b0;
    endtask : t_stall
    task automatic t_starve;
        launch(32'h80, 32'h4);
        feed(2, 32'h400);
        repeat (10) @(posedge clk_sys);
        chk("busy", {31'h0, busy}, 32'h1);
        chk("early", 32'(beats - b0), 32'h0);
        feed(2, 32'h402);
        finish(4, 32, 32'h400);
    endtask : t_starve
    task automatic t_full;
        feed(32, 32'h500);
        @(negedge clk_sys);
        chk("ready", {31'h0, user_ready}, 32'h0);
        @(posedge clk_sys);
        launch(32'h100, 32'h20);
        finish(32, 0, 32'h500);
    endtask : t_full
    task automatic t_read;
        nv = 0;
        nw = 0;
        rd_en <= 1'b1;
        for (int i = 0; i < 28; i++) begin
            @(negedge clk_sys);
            if (i == 23) rd_en <= 1'b0;
            if (master_readdatavalid) begin
                nv++;
                last = master_readdata;
            end
            if (read_word_valid) nw++;
        end
        chk("valids", 32'(nv), 32'h6);
        chk("taken", 32'(nw), 32'(nv));
        chk("rword", read_word, last);
    endtask : t_read
    task automatic results;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            results;
        end
    end
    initial begin
        {reset, go, user_valid, stall_en, rd_en} = 5'h10;
        {start_address, transfer_length, user_data} = 96'h0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_short;
        @(posedge clk_sys);
        t_long;
        @(posedge clk_sys);
        t_stall;
        @(posedge clk_sys);
        t_starve;
        @(posedge clk_sys);
        t_full;
        @(posedge clk_sys);
        launch(32'h0, 32'h0);
        finish(0, 0, 32'h0);
        t_read;
        results;
    end
endmodule : bwm_write_master_tb
